/* File: common/bssc_regs.svh */
// register offsets, field positions, reset values and timing figures of the setpoint control
`ifndef BSSC_REGS_SVH
`define BSSC_REGS_SVH

// clock
`define BSSC_CLK_PERIOD_NS     25

// soft-start durations in ns, encodings 00..11 ascending
`define BSSC_SS_T0_NS          500000
`define BSSC_SS_T1_NS          1000000
`define BSSC_SS_T2_NS          2000000
`define BSSC_SS_T3_NS          4000000

// per-code step time of a setpoint change after start-up, in ns
`define BSSC_SLEW_T0_NS        500
`define BSSC_SLEW_T1_NS        1000
`define BSSC_SLEW_T2_NS        5000
`define BSSC_SLEW_T3_NS        10000

// strap pin settling time per decoded bit, in ns
`define BSSC_STRAP_SETTLE_NS   400

// register select codes
`define BSSC_SEL_SETPOINT      2'h0
`define BSSC_SEL_MAIN          2'h1
`define BSSC_SEL_RAMP          2'h2
`define BSSC_SEL_STATUS        2'h3

// field positions
`define BSSC_RANGE_LSB         0
`define BSSC_SLEW_LSB          2
`define BSSC_SS_LSB            0

// reset and default values
`define BSSC_RANGE_RST         2'h2
`define BSSC_SS_RST            2'h1
`define BSSC_SLEW_RST          2'h0
`define BSSC_CODE_SHORT_GND    8'h46
`define BSSC_CODE_SHORT_VIN    8'h5F

// voltages in quarter millivolts
`define BSSC_BASE_LO_QMV       16'h0640
`define BSSC_BASE_HI_QMV       16'h0C80
`define BSSC_STEP_R0_QMV       16'h0005
`define BSSC_STEP_R1_QMV       16'h000A
`define BSSC_STEP_R2_QMV       16'h0014
`define BSSC_STEP_R3_QMV       16'h0028

`endif

/* File: common/bssc_pkg.sv */
// types shared by the setpoint control and its strap decoder
package bssc_pkg;

  typedef enum logic [1:0] {
    BSSC_INIT_DECODE = 2'b00,
    BSSC_INIT_LOAD   = 2'b01,
    BSSC_INIT_DONE   = 2'b10
  } bssc_init_state_type;

  typedef enum logic [1:0] {
    BSSC_DEC_IDLE = 2'b00,
    BSSC_DEC_MSB  = 2'b01,
    BSSC_DEC_LSB  = 2'b10,
    BSSC_DEC_DONE = 2'b11
  } bssc_dec_state_type;

endpackage

/* File: common/bssc_strap_if.sv */
// carrier between the control and one strap decoder
`timescale 1ns/1ps
interface bssc_strap_if;
  logic       start;
  logic       pin_level;
  logic       done;
  logic [1:0] code;
  logic       sw_a;
  logic       sw_b;

  modport ctrl (output start, output pin_level, input done, input code, input sw_a, input sw_b);
  modport dec  (input start, input pin_level, output done, output code, output sw_a, output sw_b);
endinterface

/* File: logic/bssc_strap_decoder.sv */
// two-step resistor level decoder for one strap pin
`timescale 1ns/1ps
`include "bssc_regs.svh"
module bssc_strap_decoder (
  // clock and reset
  input  wire logic   clk_in,
  input  wire logic   rst_n_in,
  // control side
  bssc_strap_if.dec   strap
);

  // least settle time, rounded up to whole cycles
  localparam int SETTLE_CYC =
    (`BSSC_STRAP_SETTLE_NS + `BSSC_CLK_PERIOD_NS - 1) / `BSSC_CLK_PERIOD_NS;

  bssc_pkg::bssc_dec_state_type state;
  bssc_pkg::bssc_dec_state_type next_state;
  logic [7:0]                   cnt;
  logic [7:0]                   next_cnt;
  logic [1:0]                   code;
  logic [1:0]                   next_code;
  logic                         sw_a;
  logic                         next_sw_a;
  logic                         sw_b;
  logic                         next_sw_b;

  // sequence: both switches open for the msb, then one switch closed for the lsb
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_code  = code;
    next_sw_a  = 1'b0;
    next_sw_b  = 1'b0;
    unique case (state)
      bssc_pkg::BSSC_DEC_IDLE: begin
        if (strap.start) begin
          next_state = bssc_pkg::BSSC_DEC_MSB;
          next_cnt   = 8'h00;
        end
      end
      bssc_pkg::BSSC_DEC_MSB: begin
        // switches stay open while the buffer reads the bare pin
        if (cnt == 8'(SETTLE_CYC - 1)) begin
          next_code[1] = strap.pin_level;
          next_cnt     = 8'h00;
          next_state   = bssc_pkg::BSSC_DEC_LSB;
          next_sw_a    = ~strap.pin_level;
          next_sw_b    = strap.pin_level;
        end else begin
          next_cnt = cnt + 8'h01;
        end
      end
      bssc_pkg::BSSC_DEC_LSB: begin
        next_sw_a = ~code[1];
        next_sw_b = code[1];
        if (cnt == 8'(SETTLE_CYC - 1)) begin
          // high reads as one with either switch, so the pin level is the lsb
          next_code[0] = strap.pin_level;
          next_sw_a    = 1'b0;
          next_sw_b    = 1'b0;
          next_state   = bssc_pkg::BSSC_DEC_DONE;
        end else begin
          next_cnt = cnt + 8'h01;
        end
      end
      bssc_pkg::BSSC_DEC_DONE: begin
        next_state = bssc_pkg::BSSC_DEC_DONE;
      end
    endcase
  end

  // decoder registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= bssc_pkg::BSSC_DEC_IDLE;
      cnt   <= 8'h00;
      code  <= 2'h0;
      sw_a  <= 1'b0;
      sw_b  <= 1'b0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      code  <= next_code;
      sw_a  <= next_sw_a;
      sw_b  <= next_sw_b;
    end
  end

  assign strap.done = (state == bssc_pkg::BSSC_DEC_DONE);
  assign strap.code = code;
  assign strap.sw_a = sw_a;
  assign strap.sw_b = sw_b;

endmodule

/* File: logic/bssc_ctrl.sv */
// setpoint, range and soft-start control of a step-down converter
//
// Overview of operation
// - two-bit soft-start field, default one millisecond
// - new settings held off until soft start ends
// - ramp to captured code first, then new code
// - force discontinuous conduction during start-up ramp
// - reference ramps fully; output follows above prebias
// - frequency strap selects one of four frequencies
// - msb sampled with both bias switches open
// - msb zero: close switch a, read lsb
// - msb one: close switch b, read lsb
// - range select picks the setpoint step size
// - range defaults to the 5 mV range
// - new range adopted only on setpoint write
// - target is base plus code times step
// - variants without serial port fix the range
// - voltage strap loads the default setpoint code
// - voltage strap also sets the target address
// - values written while disabled apply at enable
// - serial changes deferred during soft start; a setpoint walk retargets on each write
// - init holds enable low, straps, defaults, release
// - enable toggling keeps register contents
`timescale 1ns/1ps
`include "bssc_regs.svh"
module bssc_ctrl #(
  parameter int         SS0_CYC         = `BSSC_SS_T0_NS / `BSSC_CLK_PERIOD_NS,
  parameter int         SS1_CYC         = `BSSC_SS_T1_NS / `BSSC_CLK_PERIOD_NS,
  parameter int         SS2_CYC         = `BSSC_SS_T2_NS / `BSSC_CLK_PERIOD_NS,
  parameter int         SS3_CYC         = `BSSC_SS_T3_NS / `BSSC_CLK_PERIOD_NS,
  parameter logic       HAS_SERIAL      = 1'b1,
  parameter logic [7:0] CODE_RES_GND    = 8'h50,
  parameter logic [7:0] CODE_RES_VIN    = 8'h64,
  parameter logic [6:0] ADDR_BASE       = 7'h40
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // strap pins and their bias switches
  input  wire logic        frequency_strap_pin_in,
  output logic             freq_bias_switch_a_out,
  output logic             freq_bias_switch_b_out,
  input  wire logic        voltage_strap_pin_in,
  output logic             volt_bias_switch_a_out,
  output logic             volt_bias_switch_b_out,
  // enable pin
  input  wire logic        en_in,
  output logic             en_pull_low_out,
  // register access
  input  wire logic        cfg_wr_in,
  input  wire logic [1:0]  cfg_sel_in,
  input  wire logic [7:0]  cfg_data_in,
  output logic [7:0]       rd_data_out,
  output logic             serial_ready_out,
  output logic [6:0]       target_addr_out,
  // converter control
  input  wire logic        fpwm_req_in,
  input  wire logic [15:0] sensed_qmv_in,
  output logic [1:0]       freq_sel_out,
  output logic             soft_start_active_out,
  output logic             ramp_busy_out,
  output logic             force_dcm_out,
  output logic             pwm_forced_out,
  output logic [7:0]       target_voltage_code_out,
  output logic [1:0]       output_range_sel_out,
  output logic [15:0]      ref_qmv_out,
  output logic             output_follow_out
);

  // per-code step times of later setpoint changes
  localparam int SLEW0_CYC = `BSSC_SLEW_T0_NS / `BSSC_CLK_PERIOD_NS;
  localparam int SLEW1_CYC = `BSSC_SLEW_T1_NS / `BSSC_CLK_PERIOD_NS;
  localparam int SLEW2_CYC = `BSSC_SLEW_T2_NS / `BSSC_CLK_PERIOD_NS;
  localparam int SLEW3_CYC = `BSSC_SLEW_T3_NS / `BSSC_CLK_PERIOD_NS;

  // target in quarter millivolts, base plus code times step
  function automatic logic [15:0] code_to_qmv(input logic [1:0] rng, input logic [7:0] code);
    logic [15:0] step;
    logic [15:0] base;
    step = `BSSC_STEP_R2_QMV;
    base = `BSSC_BASE_LO_QMV;
    unique case (rng)
      2'h0: step = `BSSC_STEP_R0_QMV;
      2'h1: step = `BSSC_STEP_R1_QMV;
      2'h2: step = `BSSC_STEP_R2_QMV;
      2'h3: begin
        step = `BSSC_STEP_R3_QMV;
        base = `BSSC_BASE_HI_QMV;
      end
    endcase
    return base + 16'(code) * step;
  endfunction

  // cycles between reference steps; the ramp has 256 steps
  function automatic logic [17:0] ss_tick(input logic [1:0] sel);
    logic [17:0] len;
    len = 18'(SS1_CYC);
    unique case (sel)
      2'h0: len = 18'(SS0_CYC);
      2'h1: len = 18'(SS1_CYC);
      2'h2: len = 18'(SS2_CYC);
      2'h3: len = 18'(SS3_CYC);
    endcase
    return (len >> 8) == 18'h00000 ? 18'h00001 : (len >> 8);
  endfunction

  // cycles per code step when moving between setpoints
  function automatic logic [8:0] slew_tick(input logic [1:0] sel);
    logic [8:0] len;
    len = 9'(SLEW0_CYC);
    unique case (sel)
      2'h0: len = 9'(SLEW0_CYC);
      2'h1: len = 9'(SLEW1_CYC);
      2'h2: len = 9'(SLEW2_CYC);
      2'h3: len = 9'(SLEW3_CYC);
    endcase
    return len;
  endfunction

  // strap decoders
  bssc_strap_if freq_strap ();
  bssc_strap_if volt_strap ();

  bssc_strap_decoder u_freq_dec (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .strap    (freq_strap.dec)
  );

  bssc_strap_decoder u_volt_dec (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .strap    (volt_strap.dec)
  );

  bssc_pkg::bssc_init_state_type init_state;
  bssc_pkg::bssc_init_state_type next_init_state;

  assign freq_strap.start     = (init_state == bssc_pkg::BSSC_INIT_DECODE);
  assign volt_strap.start     = (init_state == bssc_pkg::BSSC_INIT_DECODE);
  assign freq_strap.pin_level = frequency_strap_pin_in;
  assign volt_strap.pin_level = voltage_strap_pin_in;

  // init sequence: decode both straps, load defaults, then open up
  always_comb begin
    next_init_state = init_state;
    unique case (init_state)
      bssc_pkg::BSSC_INIT_DECODE: begin
        if (freq_strap.done && volt_strap.done) begin
          next_init_state = bssc_pkg::BSSC_INIT_LOAD;
        end
      end
      bssc_pkg::BSSC_INIT_LOAD: next_init_state = bssc_pkg::BSSC_INIT_DONE;
      bssc_pkg::BSSC_INIT_DONE: next_init_state = bssc_pkg::BSSC_INIT_DONE;
      default:                  next_init_state = bssc_pkg::BSSC_INIT_DECODE;
    endcase
  end

  // only a supply reset re-runs init, never the enable pin
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      init_state <= bssc_pkg::BSSC_INIT_DECODE;
    end else begin
      init_state <= next_init_state;
    end
  end

  wire logic init_done = (init_state == bssc_pkg::BSSC_INIT_DONE);
  wire logic load_now  = (init_state == bssc_pkg::BSSC_INIT_LOAD);

  // written values, applied values and ramp state
  logic [7:0]  pend_code;
  logic [7:0]  next_pend_code;
  logic [1:0]  pend_range;
  logic [1:0]  next_pend_range;
  logic [1:0]  pend_slew;
  logic [1:0]  next_pend_slew;
  logic [1:0]  pend_ss;
  logic [1:0]  next_pend_ss;
  logic        range_armed;
  logic        next_range_armed;
  logic [7:0]  act_code;
  logic [7:0]  next_act_code;
  logic [1:0]  act_range;
  logic [1:0]  next_act_range;
  logic [1:0]  act_slew;
  logic [1:0]  next_act_slew;
  logic [1:0]  act_ss;
  logic [1:0]  next_act_ss;
  logic [1:0]  freq_sel;
  logic [1:0]  next_freq_sel;
  logic [1:0]  volt_code;
  logic [1:0]  next_volt_code;
  logic        en_q;
  logic        next_en_q;
  logic        ss_active;
  logic        next_ss_active;
  logic [17:0] ss_cnt;
  logic [17:0] next_ss_cnt;
  logic [8:0]  ss_idx;
  logic [8:0]  next_ss_idx;
  logic [8:0]  dvs_cnt;
  logic [8:0]  next_dvs_cnt;
  logic [15:0] ref_qmv;
  logic [15:0] next_ref_qmv;
  logic        follow;
  logic        next_follow;
  logic [7:0]  rd_data;
  logic [7:0]  next_rd_data;

  wire logic [15:0] target_qmv = code_to_qmv(act_range, act_code);
  wire logic [24:0] ramp_prod  = 25'(target_qmv) * 25'(ss_idx);
  wire logic        ss_start   = en_in && init_done && !en_q;
  wire logic        dvs_busy   = en_q && !ss_active && (act_code != pend_code || range_armed);
  wire logic        wr_ok      = cfg_wr_in && init_done && HAS_SERIAL;

  // configuration and ramp sequencing
  always_comb begin
    next_pend_code   = pend_code;
    next_pend_range  = pend_range;
    next_pend_slew   = pend_slew;
    next_pend_ss     = pend_ss;
    next_range_armed = range_armed;
    next_act_code    = act_code;
    next_act_range   = act_range;
    next_act_slew    = act_slew;
    next_act_ss      = act_ss;
    next_freq_sel    = freq_sel;
    next_volt_code   = volt_code;
    next_en_q        = en_in && init_done;
    next_ss_active   = ss_active;
    next_ss_cnt      = ss_cnt;
    next_ss_idx      = ss_idx;
    next_dvs_cnt     = dvs_cnt;
    next_ref_qmv     = ref_qmv;
    next_follow      = follow;
    if (load_now) begin
      // strap defaults, loaded once per supply reset
      next_freq_sel  = freq_strap.code;
      next_volt_code = volt_strap.code;
      unique case (volt_strap.code)
        2'h0: next_pend_code = `BSSC_CODE_SHORT_GND;
        2'h1: next_pend_code = CODE_RES_GND;
        2'h2: next_pend_code = CODE_RES_VIN;
        2'h3: next_pend_code = `BSSC_CODE_SHORT_VIN;
      endcase
      next_act_code   = next_pend_code;
      next_pend_range = `BSSC_RANGE_RST;
      next_act_range  = `BSSC_RANGE_RST;
      next_pend_ss    = `BSSC_SS_RST;
      next_act_ss     = `BSSC_SS_RST;
      next_pend_slew  = `BSSC_SLEW_RST;
      next_act_slew   = `BSSC_SLEW_RST;
    end
    if (!en_in || !init_done) begin
      // disabled: everything written waits for the next enable
      next_ss_active = 1'b0;
      next_ss_cnt    = 18'h00000;
      next_ss_idx    = 9'h000;
      next_dvs_cnt   = 9'h000;
      next_ref_qmv   = 16'h0000;
      next_follow    = 1'b0;
    end else if (ss_start) begin
      // capture the code and settings in force as the ramp begins
      next_ss_active = 1'b1;
      next_ss_cnt    = 18'h00000;
      next_ss_idx    = 9'h000;
      next_act_code  = pend_code;
      next_act_ss    = pend_ss;
      next_act_slew  = pend_slew;
      next_ref_qmv   = 16'h0000;
      if (range_armed) begin
        next_act_range   = pend_range;
        next_range_armed = 1'b0;
      end
    end else if (ss_active) begin
      // reference walks all 256 steps; applied values stay frozen
      if (ss_cnt >= ss_tick(act_ss) - 18'h00001) begin
        next_ss_cnt = 18'h00000;
        if (ss_idx == 9'h100) begin
          next_ss_active = 1'b0;
        end else begin
          next_ss_idx = ss_idx + 9'h001;
        end
      end else begin
        next_ss_cnt = ss_cnt + 18'h00001;
      end
      next_ref_qmv = ramp_prod[23:8];
      // a charged output only tracks once the reference passes it
      next_follow  = follow || (ramp_prod[23:8] > sensed_qmv_in);
    end else begin
      // settled: pending values apply, one code per slew tick
      next_follow  = 1'b1;
      next_ref_qmv = target_qmv;
      if (range_armed) begin
        // a new range changes the step size, so jump; same range walks
        next_act_range   = pend_range;
        if (pend_range != act_range) next_act_code = pend_code;
        next_range_armed = 1'b0;
      end else if (act_code != pend_code) begin
        if (dvs_cnt >= slew_tick(act_slew) - 9'h001) begin
          next_dvs_cnt  = 9'h000;
          next_act_code = (pend_code > act_code) ? act_code + 8'h01 : act_code - 8'h01;
        end else begin
          next_dvs_cnt = dvs_cnt + 9'h001;
        end
      end else begin
        // slew changes only between ramps
        next_act_slew = pend_slew;
        next_dvs_cnt  = 9'h000;
      end
    end
    // writes land in the pending copies and never touch applied values
    if (wr_ok) begin
      unique case (cfg_sel_in)
        `BSSC_SEL_SETPOINT: begin
          next_pend_code   = cfg_data_in;
          next_range_armed = 1'b1;
        end
        `BSSC_SEL_MAIN: begin
          next_pend_range = cfg_data_in[`BSSC_RANGE_LSB +: 2];
          next_pend_slew  = cfg_data_in[`BSSC_SLEW_LSB +: 2];
        end
        `BSSC_SEL_RAMP: next_pend_ss = cfg_data_in[`BSSC_SS_LSB +: 2];
        `BSSC_SEL_STATUS: next_pend_ss = pend_ss;
      endcase
    end
    if (!HAS_SERIAL) begin
      next_act_range = `BSSC_RANGE_RST;
    end
  end

  // configuration and ramp registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_code   <= `BSSC_CODE_SHORT_GND;
      pend_range  <= `BSSC_RANGE_RST;
      pend_slew   <= `BSSC_SLEW_RST;
      pend_ss     <= `BSSC_SS_RST;
      range_armed <= 1'b0;
      act_code    <= `BSSC_CODE_SHORT_GND;
      act_range   <= `BSSC_RANGE_RST;
      act_slew    <= `BSSC_SLEW_RST;
      act_ss      <= `BSSC_SS_RST;
      freq_sel    <= 2'h0;
      volt_code   <= 2'h0;
      en_q        <= 1'b0;
      ss_active   <= 1'b0;
      ss_cnt      <= 18'h00000;
      ss_idx      <= 9'h000;
      dvs_cnt     <= 9'h000;
      ref_qmv     <= 16'h0000;
      follow      <= 1'b0;
    end else begin
      pend_code   <= next_pend_code;
      pend_range  <= next_pend_range;
      pend_slew   <= next_pend_slew;
      pend_ss     <= next_pend_ss;
      range_armed <= next_range_armed;
      act_code    <= next_act_code;
      act_range   <= next_act_range;
      act_slew    <= next_act_slew;
      act_ss      <= next_act_ss;
      freq_sel    <= next_freq_sel;
      volt_code   <= next_volt_code;
      en_q        <= next_en_q;
      ss_active   <= next_ss_active;
      ss_cnt      <= next_ss_cnt;
      ss_idx      <= next_ss_idx;
      dvs_cnt     <= next_dvs_cnt;
      ref_qmv     <= next_ref_qmv;
      follow      <= next_follow;
    end
  end

  // readback of the written copies and of live status
  always_comb begin
    next_rd_data = 8'h00;
    unique case (cfg_sel_in)
      `BSSC_SEL_SETPOINT: next_rd_data = pend_code;
      `BSSC_SEL_MAIN:     next_rd_data = {4'h0, pend_slew, pend_range};
      `BSSC_SEL_RAMP:     next_rd_data = {6'h00, pend_ss};
      `BSSC_SEL_STATUS:   next_rd_data = {init_done, ss_active, dvs_busy, range_armed,
                                          freq_sel, volt_code};
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // pins and converter outputs
  assign freq_bias_switch_a_out  = freq_strap.sw_a;
  assign freq_bias_switch_b_out  = freq_strap.sw_b;
  assign volt_bias_switch_a_out  = volt_strap.sw_a;
  assign volt_bias_switch_b_out  = volt_strap.sw_b;
  assign en_pull_low_out         = !init_done;
  assign serial_ready_out        = init_done;
  assign rd_data_out             = rd_data;
  assign target_addr_out         = ADDR_BASE | {5'h00, volt_code};
  assign freq_sel_out            = freq_sel;
  assign soft_start_active_out   = ss_active;
  assign ramp_busy_out           = ss_active || dvs_busy;
  // start-up ramp overrides any forced pwm request
  assign force_dcm_out           = ss_active;
  assign pwm_forced_out          = fpwm_req_in && !ss_active;
  assign target_voltage_code_out = act_code;
  assign output_range_sel_out    = act_range;
  assign ref_qmv_out             = ref_qmv;
  assign output_follow_out       = follow;

endmodule

/* File: tb/bssc_strap_model.sv */
// strap resistor on one pin, seen through the decoder's two bias switches
`timescale 1ns/1ps
module bssc_strap_model (
  // strap state and switches
  input  wire logic [1:0] code_in,
  input  wire logic       sw_a_in,
  input  wire logic       sw_b_in,
  // pin level
  output logic            pin_out
);
  // open switches show the msb, a closed bias switch shows the lsb
  assign pin_out = (sw_a_in | sw_b_in) ? code_in[0] : code_in[1];
endmodule

/* File: tb/bssc_ctrl_asserts.sv */
// port checker of the setpoint and soft-start control
`timescale 1ns/1ps
module bssc_ctrl_asserts (
  // clock, reset, enable
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic       en_in,
  // straps and init
  input wire logic       freq_bias_switch_a_out,
  input wire logic       freq_bias_switch_b_out,
  input wire logic       volt_bias_switch_a_out,
  input wire logic       volt_bias_switch_b_out,
  input wire logic       en_pull_low_out,
  input wire logic       serial_ready_out,
  input wire logic [1:0] freq_sel_out,
  // converter control
  input wire logic       soft_start_active_out,
  input wire logic       ramp_busy_out,
  input wire logic       force_dcm_out,
  input wire logic       pwm_forced_out,
  input wire logic [7:0] target_voltage_code_out,
  input wire logic [1:0] output_range_sel_out,
  input wire logic [15:0] ref_qmv_out,
  input wire logic [15:0] sensed_qmv_in,
  input wire logic       output_follow_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_dcm_forced: assert property (soft_start_active_out |-> force_dcm_out && !pwm_forced_out)
    else $error("dcm not forced during soft start");
  a_code_frozen: assert property (soft_start_active_out &&
    $past(soft_start_active_out) |->
    $stable(target_voltage_code_out) && $stable(output_range_sel_out))
    else $error("applied setting changed during soft start");
  a_busy_in_ss: assert property (soft_start_active_out |-> ramp_busy_out)
    else $error("ramp not busy during soft start");
  a_follow_at_end: assert property ($fell(soft_start_active_out) && $past(en_in) &&
    (ref_qmv_out > $past(sensed_qmv_in)) |-> output_follow_out)
    else $error("output not following after ramp");
  a_switch_excl: assert property (
    !(freq_bias_switch_a_out && freq_bias_switch_b_out) &&
    !(volt_bias_switch_a_out && volt_bias_switch_b_out))
    else $error("both bias switches closed");
  a_init_pulls: assert property (!serial_ready_out |-> en_pull_low_out)
    else $error("enable released before init done");
  a_ready_holds: assert property (serial_ready_out |=> serial_ready_out)
    else $error("init repeated without power-up");
  a_freq_frozen: assert property (serial_ready_out [*2] |-> $stable(freq_sel_out))
    else $error("frequency changed after init");
  c_ss: cover property ($rose(soft_start_active_out));
  c_follow: cover property ($rose(output_follow_out));
  c_ready: cover property ($rose(serial_ready_out));
endmodule
bind bssc_ctrl bssc_ctrl_asserts chk (.*);

/* File: tb/tb_top.sv */
// self-checking bench of the setpoint and soft-start control
`timescale 1ns/1ps
module tb_top;
  logic        clk_in, rst_n_in, en_in, cfg_wr_in, fpwm_req_in;
  logic [1:0]  cfg_sel_in, fcode, vcode;
  logic [7:0]  cfg_data_in;
  logic [15:0] sensed_qmv_in;
  wire logic   fpin, fa, fb, vpin, va, vb, pull, rdy, ss, dcm, pwmf, follow, busy;
  wire logic [7:0]  rd, code;
  wire logic [6:0]  addr;
  wire logic [1:0]  frequency_strap_pin, rng;
  wire logic [15:0] refv;
  int          fails = 0, checked = 0, cyc = 0, n, sslen;
  // small soft-start counts keep the run short
  bssc_ctrl #(.SS0_CYC(512), .SS1_CYC(1024), .SS2_CYC(2048), .SS3_CYC(4096)) uut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .frequency_strap_pin_in(fpin),
    .freq_bias_switch_a_out(fa), .freq_bias_switch_b_out(fb), .voltage_strap_pin_in(vpin),
    .volt_bias_switch_a_out(va), .volt_bias_switch_b_out(vb), .en_in(en_in),
    .en_pull_low_out(pull), .cfg_wr_in(cfg_wr_in), .cfg_sel_in(cfg_sel_in),
    .cfg_data_in(cfg_data_in), .rd_data_out(rd), .serial_ready_out(rdy),
    .target_addr_out(addr), .fpwm_req_in(fpwm_req_in), .sensed_qmv_in(sensed_qmv_in),
    .freq_sel_out(frequency_strap_pin), .soft_start_active_out(ss), .ramp_busy_out(busy), .force_dcm_out(dcm),
    .pwm_forced_out(pwmf), .target_voltage_code_out(code), .output_range_sel_out(rng),
    .ref_qmv_out(refv), .output_follow_out(follow));
  bssc_strap_model fm (.code_in(fcode), .sw_a_in(fa), .sw_b_in(fb), .pin_out(fpin));
  bssc_strap_model vm (.code_in(vcode), .sw_a_in(va), .sw_b_in(vb), .pin_out(vpin));
  initial begin
    clk_in = 1'h0;
    forever #12.5 clk_in = ~clk_in;
  end
  // cycle limit and soft-start length counter
  always @(posedge clk_in) begin
    cyc++;
    if (ss === 1'h1) sslen++;
    if (cyc == 20000) begin
      fails++;
      wrap_up;
    end
  end
  task automatic tick;
    @(posedge clk_in);
    #2;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    tick;
    cfg_sel_in = s;
    cfg_data_in = d;
    cfg_wr_in = 1'h1;
    tick;
    cfg_wr_in = 1'h0;
  endtask
  task automatic rd_chk(input logic [1:0] s, input logic [7:0] m, input logic [7:0] e);
    tick;
    cfg_sel_in = s;
    repeat (2) tick;
    chk("readback", e, rd & m);
  endtask
  task automatic boot;
    rst_n_in = 1'h0;
    repeat (8) tick;
    rst_n_in = 1'h1;
    for (n = 0; rdy !== 1'h1 && n < 200; n++) tick;
  endtask
  task automatic wait_ss;
    for (n = 0; ss !== 1'h0 && n < 6000; n++) tick;
    repeat (3) tick;
  endtask
  // every strap state on both pins, each after a fresh power-up
  task automatic t_straps;
    logic [7:0] dflt [4] = '{8'h46, 8'h50, 8'h64, 8'h5F};
    for (int k = 0; k < 4; k++) begin
      fcode = k[1:0];
      vcode = 2'(3 - k);
      boot;
      chk("pull", 1'h0, pull);
      chk("freq", fcode, frequency_strap_pin);
      chk("code", dflt[vcode], code);
      chk("addr", 7'h40 | vcode, addr);
      chk("range", 2'h2, rng);
      rd_chk(2'h3, 8'h8F, {1'h1, 3'h0, fcode, vcode});
      rd_chk(2'h2, 8'h03, 8'h01);
    end
    $display("t_straps done");
  endtask
  // writes during soft start wait for its end
  task automatic t_soft;
    wr(2'h2, 8'h00);
    wr(2'h0, 8'h60);
    sslen = 0;
    tick;
    en_in = 1'h1;
    fpwm_req_in = 1'h1;
    repeat (3) tick;
    chk("dcm", 1'h1, dcm);
    chk("pwm", 1'h0, pwmf);
    chk("busy", 1'h1, busy);
    wr(2'h1, 8'h03);
    wr(2'h0, 8'h30);
    wr(2'h2, 8'h03);
    chk("held code", 8'h60, code);
    chk("held range", 2'h2, rng);
    rd_chk(2'h0, 8'hFF, 8'h30);
    wait_ss;
    chk("ss short", 1'h1, sslen >= 514 && sslen <= 517);
    chk("new code", 8'h30, code);
    chk("new range", 2'h3, rng);
    chk("range3 ref", 16'h1400, refv);
    chk("pwm", 1'h1, pwmf);
    wr(2'h1, 8'h02);
    repeat (4) tick;
    chk("unarmed", 2'h3, rng);
    $display("t_soft done");
  endtask
  // restart into a charged output after disabling
  task automatic t_pre;
    en_in = 1'h0;
    wr(2'h0, 8'h30);
    chk("abort", 1'h0, dcm);
    sensed_qmv_in = 16'h0900;
    sslen = 0;
    en_in = 1'h1;
    repeat (4) tick;
    chk("early", 1'h0, follow);
    wait_ss;
    chk("ss long", 1'h1, sslen >= 4112 && sslen <= 4115);
    chk("follow", 1'h1, follow);
    chk("ref", 16'h0A00, refv);
    chk("kept", 8'h30, code);
    chk("range", 2'h2, rng);
    wr(2'h0, 8'h34);
    chk("walk busy", 1'h1, busy);
    repeat (40) tick;
    chk("walk step", 8'h31, code);
    repeat (50) tick;
    chk("walk end", 8'h34, code);
    chk("walk idle", 1'h0, busy);
    $display("t_pre done");
  endtask
  task automatic wrap_up;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    {rst_n_in, en_in, cfg_wr_in, fpwm_req_in, cfg_sel_in, cfg_data_in} = '0;
    {fcode, vcode, sensed_qmv_in} = '0;
    t_straps;
    t_soft;
    t_pre;
    wrap_up;
  end
endmodule
